// *** pkg/bavs_pkg.sv ***
// package for the buck alternate-setting register bank
package bavs_pkg;
    // printed offsets are not all multiples of four: they are register indices
    localparam logic [7:0] core2_alt_voltage_idx = 8'hb4;
    localparam logic [7:0] core1_alt_voltage_idx = 8'hb5;
    localparam logic [7:0] processor_alt_voltage_idx = 8'hb6;
    localparam logic [7:0] memory_alt_voltage_idx = 8'hb7;
    localparam logic [7:0] io_alt_voltage_idx = 8'hb8;
    localparam int num_conv = 5;
    localparam int sleep_bit = 7;
    localparam int code_msb = 6;
    localparam logic [7:0] alt_reset = 8'h00;
    // output voltage in millivolts: base at code zero plus step per code
    localparam logic [11:0] core_base_mv = 12'h12c;
    localparam logic [11:0] core_step_mv = 12'h00a;
    localparam logic [11:0] proc_base_mv = 12'h212;
    localparam logic [11:0] proc_step_mv = 12'h00a;
    localparam logic [11:0] mem_base_mv = 12'h320;
    localparam logic [11:0] mem_step_mv = 12'h014;
    localparam logic [11:0] io_base_mv = 12'h320;
    localparam logic [11:0] io_step_mv = 12'h014;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef struct packed {
        logic sleep_select;
        logic [6:0] voltage_code;
    } bavs_alt_t;

    typedef struct packed {
        logic sleep;
        logic [11:0] target_mv;
    } bavs_conv_t;
endpackage : bavs_pkg

// *** logic/bavs_axil.sv ***
// axi4-lite slave front end giving one-cycle register write and read strobes
`timescale 1ns/1ps
module bavs_axil (
    input wire logic sys_clk, // register clock
    input wire logic rst_b, // async reset, active low
    input wire logic [31:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [31:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic wr_stb, // one-cycle write strobe
    output logic [31:0] wr_addr, // write byte address
    output logic [7:0] wr_byte, // write data lane 0
    output logic wr_lane0, // lane 0 enabled
    input wire logic wr_ok, // write address mapped
    output logic rd_stb, // one-cycle read strobe
    output logic [31:0] rd_addr, // read byte address
    input wire logic [7:0] rd_byte, // read data
    input wire logic rd_ok // read address mapped
);
    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } bavs_axil_state_t;

    bavs_axil_state_t st;
    bavs_axil_state_t next_st;
    logic do_wr;

    // address and data are accepted in either order; the write fires once both are held
    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready = !st.w_held && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign do_wr = st.aw_held && st.w_held && !st.bvalid;
    assign wr_stb = do_wr;
    assign wr_addr = st.awaddr;
    assign wr_byte = st.wdata[7:0];
    assign wr_lane0 = st.wstrb[0];
    assign rd_stb = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;

    always_comb begin
        next_st = st;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_ok ? bavs_pkg::resp_okay : bavs_pkg::resp_slverr;
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (rd_stb) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = rd_ok ? bavs_pkg::resp_okay : bavs_pkg::resp_slverr;
            next_st.rdata = {24'h000000, rd_byte};
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : bavs_axil

// *** logic/bavs_conv_map.sv ***
// maps one alternate setting to the converter's sleep choice and target voltage
`timescale 1ns/1ps
module bavs_conv_map (
    input wire logic sys_clk, // register clock
    input wire logic rst_b, // async reset, active low
    input wire logic [11:0] base_mv, // voltage at code zero
    input wire logic [11:0] step_mv, // voltage per code step
    input wire bavs_pkg::bavs_alt_t alt, // stored alternate setting
    output bavs_pkg::bavs_conv_t conv // registered mode and target
);
    bavs_pkg::bavs_conv_t next_conv;

    function automatic logic [11:0] code_to_mv(input logic [11:0] base, input logic [11:0] step,
                                               input logic [6:0] code);
        logic [18:0] prod;
        prod = step * code;
        code_to_mv = base + prod[11:0];
    endfunction : code_to_mv

    always_comb begin
        next_conv.sleep = alt.sleep_select;
        next_conv.target_mv = code_to_mv(base_mv, step_mv, alt.voltage_code);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            conv <= '0;
        end else begin
            conv <= next_conv;
        end
    end
endmodule : bavs_conv_map

// *** logic/bavs_bank.sv ***
// alternate-setting register bank for five step-down converters over axi4-lite
`timescale 1ns/1ps
module bavs_bank (
    input wire logic sys_clk, // register clock, 25 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic [31:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [31:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output bavs_pkg::bavs_conv_t second_core_converter, // sleep and target mV
    output bavs_pkg::bavs_conv_t first_core_converter, // sleep and target mV
    output bavs_pkg::bavs_conv_t processor_converter, // sleep and target mV
    output bavs_pkg::bavs_conv_t memory_converter, // sleep and target mV
    output bavs_pkg::bavs_conv_t io_converter // sleep and target mV
);
    typedef struct packed {
        bavs_pkg::bavs_alt_t [bavs_pkg::num_conv-1:0] alt;
    } bavs_bank_state_t;

    bavs_bank_state_t st;
    bavs_bank_state_t next_st;
    logic wr_stb;
    logic [31:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane0;
    logic wr_ok;
    logic rd_stb;
    logic [31:0] rd_addr;
    logic [7:0] rd_byte;
    logic rd_ok;
    logic [2:0] wr_slot;
    logic [2:0] rd_slot;
    logic [3:0] wr_dec;
    logic [3:0] rd_dec;

    // byte address is four times the register index; slot 0 is the second core register
    function automatic logic [3:0] decode(input logic [31:0] addr);
        logic [31:0] idx;
        idx = addr >> 2;
        if (addr[1:0] != 2'h0 || addr[31:10] != 22'h000000) begin
            decode = 4'h8;
        end else if (idx[7:0] >= bavs_pkg::core2_alt_voltage_idx &&
                     idx[7:0] <= bavs_pkg::io_alt_voltage_idx) begin
            decode = {1'b0, 3'(idx[7:0] - bavs_pkg::core2_alt_voltage_idx)};
        end else begin
            decode = 4'h8;
        end
    endfunction : decode

    // bit 3 of the decode flags an unmapped or unaligned address
    assign wr_dec = decode(wr_addr);
    assign rd_dec = decode(rd_addr);
    assign wr_ok = ~wr_dec[3];
    assign wr_slot = wr_dec[2:0];
    assign rd_ok = ~rd_dec[3];
    assign rd_slot = rd_dec[2:0];
    assign rd_byte = rd_ok ? st.alt[rd_slot] : 8'h00;

    bavs_axil u_axil (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_byte(wr_byte),
        .wr_lane0(wr_lane0),
        .wr_ok(wr_ok),
        .rd_stb(rd_stb),
        .rd_addr(rd_addr),
        .rd_byte(rd_byte),
        .rd_ok(rd_ok)
    );

    // reads have no side effect; only a mapped write with lane 0 enabled changes state
    always_comb begin
        next_st = st;
        if (wr_stb && wr_ok && wr_lane0) begin
            next_st.alt[wr_slot] = wr_byte;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= {bavs_pkg::num_conv{bavs_pkg::alt_reset}};
        end else begin
            st <= next_st;
        end
    end

    // sleep bit passes straight through as the mode choice; code scales linearly
    bavs_conv_map u_core2 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .base_mv(bavs_pkg::core_base_mv),
        .step_mv(bavs_pkg::core_step_mv),
        .alt(st.alt[0]),
        .conv(second_core_converter)
    );

    bavs_conv_map u_core1 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .base_mv(bavs_pkg::core_base_mv),
        .step_mv(bavs_pkg::core_step_mv),
        .alt(st.alt[1]),
        .conv(first_core_converter)
    );

    bavs_conv_map u_proc (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .base_mv(bavs_pkg::proc_base_mv),
        .step_mv(bavs_pkg::proc_step_mv),
        .alt(st.alt[2]),
        .conv(processor_converter)
    );

    bavs_conv_map u_mem (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .base_mv(bavs_pkg::mem_base_mv),
        .step_mv(bavs_pkg::mem_step_mv),
        .alt(st.alt[3]),
        .conv(memory_converter)
    );

    bavs_conv_map u_io (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .base_mv(bavs_pkg::io_base_mv),
        .step_mv(bavs_pkg::io_step_mv),
        .alt(st.alt[4]),
        .conv(io_converter)
    );
endmodule : bavs_bank

// *** verification/bavs_bank_asserts.sv ***
// concurrent checks on the alternate-setting bank ports
`timescale 1ns/1ps
module bavs_bank_asserts (
    input wire logic sys_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic [31:0] s_axi_awaddr, // aw address
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic [31:0] s_axi_wdata, // w data
    input wire logic [3:0] s_axi_wstrb, // w strobes
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire bavs_pkg::bavs_conv_t second_core_converter, // core2 out
    input wire bavs_pkg::bavs_conv_t first_core_converter, // core1 out
    input wire bavs_pkg::bavs_conv_t processor_converter, // processor out
    input wire bavs_pkg::bavs_conv_t memory_converter, // memory out
    input wire bavs_pkg::bavs_conv_t io_converter // io out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [31:0] last_addr;
    logic [7:0] last_data;
    logic last_lane;
    // aw and w may be taken on different edges, so each is kept on its own
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_addr <= 32'h00000000;
            last_data <= 8'h00;
            last_lane <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) last_addr <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) last_data <= s_axi_wdata[7:0];
            if (s_axi_wvalid && s_axi_wready) last_lane <= s_axi_wstrb[0];
        end
    end
    sequence wr_done(logic [7:0] idx);
        $rose(s_axi_bvalid) && s_axi_bresp == bavs_pkg::resp_okay && last_lane
            && last_addr == {22'h000000, idx, 2'h0};
    endsequence
    property wr_map(logic [7:0] idx, logic [11:0] b, logic [11:0] s, bavs_pkg::bavs_conv_t cv);
        wr_done(idx) |-> ##[1:3] (cv.sleep == last_data[7]
            && cv.target_mv == b + s * {5'h00, last_data[6:0]});
    endproperty
    core2_write_a: assert property (wr_map(bavs_pkg::core2_alt_voltage_idx,
        bavs_pkg::core_base_mv, bavs_pkg::core_step_mv, second_core_converter))
        else $error("second core setting not applied");
    core1_write_a: assert property (wr_map(bavs_pkg::core1_alt_voltage_idx,
        bavs_pkg::core_base_mv, bavs_pkg::core_step_mv, first_core_converter))
        else $error("first core setting not applied");
    proc_write_a: assert property (wr_map(bavs_pkg::processor_alt_voltage_idx,
        bavs_pkg::proc_base_mv, bavs_pkg::proc_step_mv, processor_converter))
        else $error("processor setting not applied");
    mem_write_a: assert property (wr_map(bavs_pkg::memory_alt_voltage_idx,
        bavs_pkg::mem_base_mv, bavs_pkg::mem_step_mv, memory_converter))
        else $error("memory setting not applied");
    io_write_a: assert property (wr_map(bavs_pkg::io_alt_voltage_idx,
        bavs_pkg::io_base_mv, bavs_pkg::io_step_mv, io_converter))
        else $error("io setting not applied");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule : bavs_bank_asserts

bind bavs_bank bavs_bank_asserts bavs_bank_asserts_inst (.sys_clk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .second_core_converter, .first_core_converter, .processor_converter, .memory_converter,
    .io_converter);

// *** verification/bavs_bank_bench.sv ***
// self-checking bench for the alternate-setting register bank
`timescale 1ns/1ps
module bavs_bank_bench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    bavs_pkg::bavs_conv_t conv [5];
    int mismatches = 0, comparisons = 0, cycles = 0;
    logic [7:0] pat [4] = '{8'hff, 8'h00, 8'ha5, 8'h11};

    bavs_bank bavs_bank_inst (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .second_core_converter(conv[0]),
        .first_core_converter(conv[1]), .processor_converter(conv[2]),
        .memory_converter(conv[3]), .io_converter(conv[4]));

    initial forever #20 sys_clk = ~sys_clk;

    task automatic final_report();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // a hung handshake would otherwise stall the run forever
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    function automatic logic [31:0] reg_addr(input int i);
        logic [7:0] x;
        x = (i == 0) ? bavs_pkg::core2_alt_voltage_idx : (i == 1) ?
            bavs_pkg::core1_alt_voltage_idx : (i == 2) ? bavs_pkg::processor_alt_voltage_idx :
            (i == 3) ? bavs_pkg::memory_alt_voltage_idx : bavs_pkg::io_alt_voltage_idx;
        return {22'h000000, x, 2'h0};
    endfunction : reg_addr

    function automatic logic [31:0] exp_conv(input int i, input logic [7:0] d);
        logic [11:0] b;
        logic [11:0] s;
        b = (i < 2) ? bavs_pkg::core_base_mv : (i == 2) ? bavs_pkg::proc_base_mv :
            (i == 3) ? bavs_pkg::mem_base_mv : bavs_pkg::io_base_mv;
        s = (i < 2) ? bavs_pkg::core_step_mv : (i == 2) ? bavs_pkg::proc_step_mv :
            (i == 3) ? bavs_pkg::mem_step_mv : bavs_pkg::io_step_mv;
        return {19'h00000, d[7], 12'(b + s * {5'h00, d[6:0]})};
    endfunction : exp_conv

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] st,
                             input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check_val({30'h0, s_axi_bresp}, {30'h0, r});
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check_val(s_axi_rdata, d);
        check_val({30'h0, s_axi_rresp}, {30'h0, r});
    endtask : axi_read

    // outputs lag the register by one cycle after the response edge
    task automatic conv_is(input int i, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        check_val({19'h00000, conv[i]}, exp_conv(i, d));
    endtask : conv_is

    // printed anchor voltages in mV, kept apart from the package scaling constants
    task automatic mv_is(input int i, input logic top);
        logic [11:0] v;
        if (i < 2) v = top ? 12'h622 : 12'h12c;
        else if (i == 2) v = top ? 12'h708 : 12'h212;
        else v = top ? 12'hd0c : 12'h320;
        check_val({20'h00000, conv[i].target_mv}, {20'h00000, v});
    endtask : mv_is

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            axi_read(reg_addr(i), 32'h0, bavs_pkg::resp_okay);
            conv_is(i, 8'h00);
            mv_is(i, 1'b0);
            // top code, zero, a mid value with sleep, then a value unique to each register
            for (int k = 0; k < 4; k++) begin
                axi_write(reg_addr(i), {24'hffffff, pat[k] + 8'(k / 3 * i)}, 4'hf,
                          bavs_pkg::resp_okay);
                conv_is(i, pat[k] + 8'(k / 3 * i));
                if (k == 0) mv_is(i, 1'b1);
                axi_read(reg_addr(i), {24'h0, pat[k] + 8'(k / 3 * i)}, bavs_pkg::resp_okay);
            end
        end
        axi_write(reg_addr(0), 32'h000000ff, 4'he, bavs_pkg::resp_okay);
        axi_write(32'h000002e4, 32'h000000ff, 4'hf, bavs_pkg::resp_slverr);
        axi_read(32'h000002e4, 32'h0, bavs_pkg::resp_slverr);
        axi_read(32'h000002d1, 32'h0, bavs_pkg::resp_slverr);
        for (int i = 0; i < 5; i++) begin
            axi_read(reg_addr(i), 32'h11 + i, bavs_pkg::resp_okay);
            conv_is(i, 8'h11 + 8'(i));
        end
        check_val({20'h00000, conv[3].target_mv}, 32'h000004b0);
        final_report();
    end
endmodule : bavs_bank_bench
